// file: core/mbrm_params.svh
// constants for the modbus measurement register map
`ifndef MBRM_PARAMS_SVH
`define MBRM_PARAMS_SVH

// ==========================================================
// timing
`define MBRM_CLK_HZ 10000000
`define MBRM_BAUD 19200
`define MBRM_BIT_CYC (`MBRM_CLK_HZ / `MBRM_BAUD)
`define MBRM_GAP_US 2005
`define MBRM_GAP_CYC ((`MBRM_CLK_HZ / 1000000) * `MBRM_GAP_US)

// ==========================================================
// protocol codes
`define MBRM_ADDR_RST 8'hf0
`define MBRM_FC_READ 8'h03
`define MBRM_FC_WRITE 8'h10
`define MBRM_FC_MEI 8'h2b
`define MBRM_MEI_IDENT 8'h0e
`define MBRM_EXC_FUNC 8'h01
`define MBRM_EXC_ADDR 8'h02
`define MBRM_EXC_VALUE 8'h03
`define MBRM_MAX_READ 16'h007d
`define MBRM_MAX_WRITE 16'h007b
`define MBRM_NQ 21

// ==========================================================
// 16-bit integer encoding
`define MBRM_INT_PAGE 8'h01
`define MBRM_NA_CODE 16'h8000
`define MBRM_SAT_HI 16'h7fff
`define MBRM_SAT_LO 16'h8001
`define MBRM_SAT_HI_VAL 32767
`define MBRM_SAT_LO_VAL -32767

// ==========================================================
// float measurement offsets
`define MBRM_OFS_HUMIDITY_RELATIVE 16'h0000
`define MBRM_OFS_TEMPERATURE 16'h0002
`define MBRM_OFS_DEWPOINT 16'h0006
`define MBRM_OFS_DEW_FROST_POINT 16'h0008
`define MBRM_OFS_DEW_FROST_POINT_ATM 16'h000a
`define MBRM_OFS_DEWPOINT_ATM 16'h000c
`define MBRM_OFS_HUMIDITY_ABSOLUTE 16'h000e
`define MBRM_OFS_MIXING_RATIO 16'h0010
`define MBRM_OFS_WET_BULB 16'h0012
`define MBRM_OFS_WATER_CONCENTRATION 16'h0014
`define MBRM_OFS_VAPOR_PRESSURE 16'h0016
`define MBRM_OFS_SATURATION_PRESSURE 16'h0018
`define MBRM_OFS_ENTHALPY 16'h001a
`define MBRM_OFS_WATER_ACTIVITY 16'h001c
`define MBRM_OFS_DEWPOINT_DIFFERENCE 16'h001e
`define MBRM_OFS_HUMIDITY_ABSOLUTE_NTP 16'h0020
`define MBRM_OFS_WATER_IN_OIL 16'h0022
`define MBRM_OFS_SATURATION_RELATIVE 16'h0028
`define MBRM_OFS_WATER_WET_BASIS 16'h002a
`define MBRM_OFS_HUMIDITY_RELATIVE_FROST 16'h002c
`define MBRM_OFS_WATER_MASS_FRACTION 16'h0040

`endif

// file: core/mbrm_pkg.sv
// types for the modbus measurement register map
package mbrm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_SEND = 2'b11,
    ST_WAIT = 2'b10
  } mbrm_state_t;
  typedef enum logic [1:0] {
    RK_EXC = 2'b00,
    RK_READ = 2'b01,
    RK_IDENT = 2'b10
  } mbrm_resp_t;
endpackage

// file: core/mbrm_uart.sv
// 8n2 serial receiver and transmitter for the rs-485 line
`timescale 1ns/1ps
module mbrm_uart #(
  parameter int BIT_CYC = 520
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic rx_in,
  input wire logic tx_go_in,
  input wire logic [7:0] tx_byte_in,
  output logic [7:0] rx_byte_out,
  output logic rx_stb_out,
  output logic tx_rdy_out,
  output logic tx_out
);
  localparam int CW = $clog2(BIT_CYC + 1);

  // ==========================================================
  // receive
  logic rx_s1_reg, rx_s2_reg, rx_act_reg;
  logic [CW-1:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  always_ff @(posedge clock_in) begin
    rx_s1_reg <= rx_in;
    rx_s2_reg <= rx_s1_reg;
  end
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rx_act_reg <= 1'b0;
      rx_cnt_reg <= '0;
      rx_bit_reg <= 4'h0;
      rx_byte_out <= 8'h00;
      rx_stb_out <= 1'b0;
    end else begin
      rx_stb_out <= 1'b0;
      if (!rx_act_reg) begin
        if (!rx_s2_reg) begin
          // sample each bit mid-cell
          rx_act_reg <= 1'b1;
          rx_cnt_reg <= CW'(BIT_CYC / 2);
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end else begin
        rx_cnt_reg <= CW'(BIT_CYC - 1);
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rx_s2_reg) begin
          rx_act_reg <= 1'b0;
        end else if (rx_bit_reg == 4'h9) begin
          // a bad stop bit drops the character
          rx_act_reg <= 1'b0;
          rx_stb_out <= rx_s2_reg;
        end else if (rx_bit_reg != 4'h0) begin
          rx_byte_out <= {rx_s2_reg, rx_byte_out[7:1]};
        end
      end
    end
  end

  // ==========================================================
  // transmit: start, eight data lsb first, two stops
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_n_reg;
  logic [CW-1:0] tx_cnt_reg;
  logic tx_tick;
  assign tx_tick = !tx_rdy_out && tx_cnt_reg == '0 && tx_n_reg != 4'h0;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_out <= 1'b1;
      tx_rdy_out <= 1'b1;
      tx_sh_reg <= 11'h7ff;
      tx_n_reg <= 4'h0;
      tx_cnt_reg <= '0;
    end else if (tx_rdy_out && tx_go_in) begin
      tx_sh_reg <= {2'b11, tx_byte_in, 1'b0};
      tx_n_reg <= 4'hb;
      tx_cnt_reg <= '0;
      tx_rdy_out <= 1'b0;
    end else if (!tx_rdy_out) begin
      if (tx_cnt_reg != '0) begin
        tx_cnt_reg <= tx_cnt_reg - 1'b1;
      end else if (tx_n_reg == 4'h0) begin
        tx_rdy_out <= 1'b1;
      end else begin
        tx_out <= tx_sh_reg[0];
        tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
        tx_n_reg <= tx_n_reg - 4'h1;
        tx_cnt_reg <= CW'(BIT_CYC - 1);
      end
    end
  end

  property p_bit_time;
    @(posedge clock_in) disable iff (sys_rst_in)
      $changed(tx_out) |-> $past(tx_tick);
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("line changed away from a bit boundary");
endmodule

// file: core/mbrm_regmap.sv
// modbus rtu slave serving the read-only measurement register map
`timescale 1ns/1ps
`include "mbrm_params.svh"
module mbrm_regmap
  import mbrm_pkg::*;
#(
  parameter int GAP_CYC = `MBRM_GAP_CYC,
  parameter int BIT_CYC = `MBRM_BIT_CYC,
  parameter int NQ = `MBRM_NQ,
  parameter logic [7:0] VENDOR_CODE = 8'h5a // arbitrary value
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic rs485_rx_in,
  input wire logic addr_set_in,
  input wire logic [7:0] addr_in,
  input wire logic meas_update_in,
  input wire logic [NQ*32-1:0] meas_f32_in,
  input wire logic [NQ*32-1:0] meas_scaled_in,
  input wire logic [NQ-1:0] meas_avail_in,
  output logic rs485_tx_out,
  output logic rs485_de_out,
  output logic busy_out,
  output logic [7:0] slave_addr_out
);
  localparam int GW = $clog2(GAP_CYC + 1);

  // ==========================================================
  // helpers
  function automatic logic [15:0] crc16(input logic [15:0] c,
                                        input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction

  // saturation and not-available sentinels of the 16-bit form
  function automatic logic [15:0] enc16(input logic [31:0] v,
                                        input logic ok);
    if (!ok) begin
      return `MBRM_NA_CODE;
    end else if ($signed(v) >= `MBRM_SAT_HI_VAL) begin
      return `MBRM_SAT_HI;
    end else if ($signed(v) <= `MBRM_SAT_LO_VAL) begin
      return `MBRM_SAT_LO;
    end else begin
      return v[15:0];
    end
  endfunction

  // quantity index of a float register pair, 31 when unmapped
  function automatic logic [4:0] fidx(input logic [15:0] a);
    case ({a[15:1], 1'b0})
      `MBRM_OFS_HUMIDITY_RELATIVE: return 5'd0;
      `MBRM_OFS_TEMPERATURE: return 5'd1;
      `MBRM_OFS_DEWPOINT: return 5'd2;
      `MBRM_OFS_DEW_FROST_POINT: return 5'd3;
      `MBRM_OFS_DEW_FROST_POINT_ATM: return 5'd4;
      `MBRM_OFS_DEWPOINT_ATM: return 5'd5;
      `MBRM_OFS_HUMIDITY_ABSOLUTE: return 5'd6;
      `MBRM_OFS_MIXING_RATIO: return 5'd7;
      `MBRM_OFS_WET_BULB: return 5'd8;
      `MBRM_OFS_WATER_CONCENTRATION: return 5'd9;
      `MBRM_OFS_VAPOR_PRESSURE: return 5'd10;
      `MBRM_OFS_SATURATION_PRESSURE: return 5'd11;
      `MBRM_OFS_ENTHALPY: return 5'd12;
      `MBRM_OFS_WATER_ACTIVITY: return 5'd13;
      `MBRM_OFS_DEWPOINT_DIFFERENCE: return 5'd14;
      `MBRM_OFS_HUMIDITY_ABSOLUTE_NTP: return 5'd15;
      `MBRM_OFS_WATER_IN_OIL: return 5'd16;
      `MBRM_OFS_SATURATION_RELATIVE: return 5'd17;
      `MBRM_OFS_WATER_WET_BASIS: return 5'd18;
      `MBRM_OFS_HUMIDITY_RELATIVE_FROST: return 5'd19;
      `MBRM_OFS_WATER_MASS_FRACTION: return 5'd20;
      default: return 5'd31;
    endcase
  endfunction

  // ==========================================================
  // measurement store: live copy and per-request snapshot
  logic [31:0] live_f [0:NQ-1];
  logic [15:0] live_i [0:NQ-1];
  logic [31:0] snap_f [0:NQ-1];
  logic [15:0] snap_i [0:NQ-1];

  // {mapped, word} of a pdu address, numbers already zero based
  function automatic logic [16:0] reg_look(input logic [15:0] a);
    logic [4:0] i;
    i = 5'd31;
    if (a[15:8] == `MBRM_INT_PAGE) begin
      // the integer page mirrors the float map at half the offset
      i = fidx({7'h00, a[7:0], 1'b0});
      if (i != 5'd31) begin
        return {1'b1, snap_i[i]};
      end
    end else if (a[15:8] == 8'h00) begin
      i = fidx(a);
      if (i != 5'd31) begin
        return {1'b1, a[0] ? snap_f[i][31:16] : snap_f[i][15:0]};
      end
    end
    return 17'h00000;
  endfunction

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NQ; i++) begin
        live_f[i] <= 32'h00000000;
        live_i[i] <= `MBRM_NA_CODE;
      end
    end else if (meas_update_in) begin
      for (int i = 0; i < NQ; i++) begin
        live_f[i] <= meas_f32_in[i*32 +: 32];
        live_i[i] <= enc16(meas_scaled_in[i*32 +: 32], meas_avail_in[i]);
      end
    end
  end

  // ==========================================================
  // serial line
  logic [7:0] rx_byte, tx_byte_reg;
  logic rx_stb, tx_rdy, tx_go_reg;

  mbrm_uart #(.BIT_CYC(BIT_CYC)) u_uart (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .rx_in(rs485_rx_in),
    .tx_go_in(tx_go_reg),
    .tx_byte_in(tx_byte_reg),
    .rx_byte_out(rx_byte),
    .rx_stb_out(rx_stb),
    .tx_rdy_out(tx_rdy),
    .tx_out(rs485_tx_out)
  );

  // ==========================================================
  // slave address
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      slave_addr_out <= `MBRM_ADDR_RST;
    end else if (addr_set_in) begin
      slave_addr_out <= addr_in;
    end
  end

  // ==========================================================
  // frame reception, ended by a silent gap
  mbrm_state_t state_reg;
  logic [7:0] req_reg [0:7];
  logic [8:0] rx_cnt_reg;
  logic [15:0] rx_crc_reg;
  logic [GW-1:0] gap_reg;
  logic frame_end, frame_ok;

  assign frame_end = state_reg == ST_IDLE && rx_cnt_reg != 9'd0 &&
                     gap_reg == GW'(GAP_CYC - 1);
  // broadcasts are dropped: nothing here can be written
  assign frame_ok = rx_cnt_reg >= 9'd4 && rx_crc_reg == 16'h0000 &&
                    req_reg[0] == slave_addr_out;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rx_cnt_reg <= 9'd0;
      rx_crc_reg <= 16'hffff;
      gap_reg <= '0;
      for (int i = 0; i < 8; i++) begin
        req_reg[i] <= 8'h00;
      end
    end else if (rx_stb && state_reg == ST_IDLE) begin
      gap_reg <= '0;
      rx_crc_reg <= crc16(rx_crc_reg, rx_byte);
      if (rx_cnt_reg < 9'd8) begin
        req_reg[rx_cnt_reg[2:0]] <= rx_byte;
      end
      if (rx_cnt_reg != 9'h1ff) begin
        rx_cnt_reg <= rx_cnt_reg + 9'd1;
      end
    end else if (frame_end || state_reg != ST_IDLE) begin
      // bytes heard while answering are not part of any frame
      rx_cnt_reg <= 9'd0;
      rx_crc_reg <= 16'hffff;
      gap_reg <= '0;
    end else if (rx_cnt_reg != 9'd0) begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  // ==========================================================
  // request decode
  logic [15:0] req_qty;
  mbrm_resp_t dec_kind;
  logic [7:0] dec_exc;
  assign req_qty = {req_reg[4], req_reg[5]};
  always_comb begin
    dec_kind = RK_EXC;
    dec_exc = `MBRM_EXC_FUNC;
    case (req_reg[1])
      `MBRM_FC_READ: begin
        if (rx_cnt_reg != 9'd8 || req_qty == 16'h0000 ||
            req_qty > `MBRM_MAX_READ) begin
          dec_exc = `MBRM_EXC_VALUE;
        end else begin
          dec_kind = RK_READ;
        end
      end
      `MBRM_FC_WRITE: begin
        // every mapped register is read-only
        dec_exc = (req_qty == 16'h0000 || req_qty > `MBRM_MAX_WRITE) ?
                  `MBRM_EXC_VALUE : `MBRM_EXC_ADDR;
      end
      `MBRM_FC_MEI: begin
        if (req_reg[2] == `MBRM_MEI_IDENT && req_reg[3] != 8'h00 &&
            req_reg[3] < 8'h05) begin
          dec_kind = RK_IDENT;
        end else begin
          dec_exc = `MBRM_EXC_VALUE;
        end
      end
      default: dec_exc = `MBRM_EXC_FUNC;
    endcase
  end

  // ==========================================================
  // response sequencing
  mbrm_resp_t kind_reg;
  logic [7:0] exc_reg, fc_reg, code_reg;
  logic [15:0] start_reg, qty_reg, chk_reg, tx_crc_reg;
  logic [8:0] pos_reg, len_reg;
  logic [16:0] chk_look;
  logic send_now;
  assign chk_look = reg_look(start_reg + chk_reg);
  assign send_now = state_reg == ST_SEND && tx_rdy && !tx_go_reg;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      kind_reg <= RK_EXC;
      exc_reg <= 8'h00;
      fc_reg <= 8'h00;
      code_reg <= 8'h00;
      start_reg <= 16'h0000;
      qty_reg <= 16'h0000;
      chk_reg <= 16'h0000;
      len_reg <= 9'd0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (frame_end && frame_ok) begin
            kind_reg <= dec_kind;
            exc_reg <= dec_exc;
            fc_reg <= req_reg[1];
            code_reg <= req_reg[3];
            start_reg <= {req_reg[2], req_reg[3]};
            qty_reg <= req_qty;
            chk_reg <= 16'h0000;
            len_reg <= (dec_kind == RK_IDENT) ? 9'd11 : 9'd3;
            state_reg <= (dec_kind == RK_READ) ? ST_CHECK : ST_SEND;
          end
        end
        ST_CHECK: begin
          // whole range must be mapped before any data goes out
          if (!chk_look[16]) begin
            kind_reg <= RK_EXC;
            exc_reg <= `MBRM_EXC_ADDR;
            state_reg <= ST_SEND;
          end else if (chk_reg == qty_reg - 16'h0001) begin
            len_reg <= 9'd3 + {qty_reg[7:0], 1'b0};
            state_reg <= ST_SEND;
          end else begin
            chk_reg <= chk_reg + 16'h0001;
          end
        end
        ST_SEND: begin
          if (send_now && pos_reg == len_reg + 9'd1) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tx_rdy && !tx_go_reg) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // snapshot taken when a request is accepted
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NQ; i++) begin
        snap_f[i] <= 32'h00000000;
        snap_i[i] <= `MBRM_NA_CODE;
      end
    end else if (frame_end && frame_ok) begin
      for (int i = 0; i < NQ; i++) begin
        snap_f[i] <= live_f[i];
        snap_i[i] <= live_i[i];
      end
    end
  end

  // ==========================================================
  // byte generation
  logic [7:0] body_byte, cur_byte;
  logic [8:0] k;
  logic [16:0] rd_look;
  assign k = pos_reg - 9'd3;
  assign rd_look = reg_look(start_reg + {8'h00, k[8:1]});
  always_comb begin
    body_byte = 8'h00;
    if (pos_reg == 9'd0) begin
      body_byte = slave_addr_out;
    end else begin
      case (kind_reg)
        RK_READ: begin
          if (pos_reg == 9'd1) begin
            body_byte = `MBRM_FC_READ;
          end else if (pos_reg == 9'd2) begin
            body_byte = {qty_reg[6:0], 1'b0};
          end else begin
            body_byte = k[0] ? rd_look[7:0] : rd_look[15:8];
          end
        end
        RK_IDENT: begin
          case (pos_reg)
            9'd1: body_byte = `MBRM_FC_MEI;
            9'd2: body_byte = `MBRM_MEI_IDENT;
            9'd3: body_byte = code_reg;
            9'd4: body_byte = 8'h01;
            9'd7: body_byte = 8'h01;
            9'd9: body_byte = 8'h01;
            9'd10: body_byte = VENDOR_CODE;
            default: body_byte = 8'h00;
          endcase
        end
        default: begin
          body_byte = (pos_reg == 9'd1) ? (fc_reg | 8'h80) : exc_reg;
        end
      endcase
    end
  end
  assign cur_byte = (pos_reg < len_reg) ? body_byte :
                    (pos_reg == len_reg) ? tx_crc_reg[7:0] :
                    tx_crc_reg[15:8];

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_go_reg <= 1'b0;
      tx_byte_reg <= 8'hff;
      pos_reg <= 9'd0;
      tx_crc_reg <= 16'hffff;
    end else begin
      tx_go_reg <= send_now;
      if (state_reg == ST_IDLE) begin
        pos_reg <= 9'd0;
        tx_crc_reg <= 16'hffff;
      end else if (send_now) begin
        tx_byte_reg <= cur_byte;
        pos_reg <= pos_reg + 9'd1;
        if (pos_reg < len_reg) begin
          tx_crc_reg <= crc16(tx_crc_reg, cur_byte);
        end
      end
    end
  end

  // driver enabled from the first byte until the last stop bit
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rs485_de_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      rs485_de_out <= state_reg == ST_SEND || state_reg == ST_WAIT ||
                      !tx_rdy;
      busy_out <= state_reg != ST_IDLE;
    end
  end

  // ==========================================================
  // checks
  property p_de_cover;
    @(posedge clock_in) disable iff (sys_rst_in)
      !tx_rdy |-> rs485_de_out;
  endproperty
  a_de_cover: assert property (p_de_cover)
    else $error("line driven without driver enable");

  property p_na;
    @(posedge clock_in) disable iff (sys_rst_in)
      meas_update_in && !meas_avail_in[6] |=> live_i[6] == 16'h8000;
  endproperty
  a_na: assert property (p_na)
    else $error("unavailable value not 8000");

  property p_sat_hi;
    @(posedge clock_in) disable iff (sys_rst_in)
      meas_update_in && meas_avail_in[3] &&
      $signed(meas_scaled_in[127:96]) > 32766 |=> live_i[3] == 16'h7fff;
  endproperty
  a_sat_hi: assert property (p_sat_hi)
    else $error("high value not saturated");

  property p_sat_lo;
    @(posedge clock_in) disable iff (sys_rst_in)
      meas_update_in && meas_avail_in[4] &&
      $signed(meas_scaled_in[159:128]) < -32766 |=> live_i[4] == 16'h8001;
  endproperty
  a_sat_lo: assert property (p_sat_lo)
    else $error("low value not saturated");

  property p_mid;
    @(posedge clock_in) disable iff (sys_rst_in)
      meas_update_in && meas_avail_in[2] &&
      $signed(meas_scaled_in[95:64]) >= 0 &&
      $signed(meas_scaled_in[95:64]) <= 32766
      |=> live_i[2] == $past(meas_scaled_in[79:64]) && !live_i[2][15];
  endproperty
  a_mid: assert property (p_mid)
    else $error("in-range value altered");

  property p_neg;
    @(posedge clock_in) disable iff (sys_rst_in)
      meas_update_in && meas_avail_in[5] &&
      $signed(meas_scaled_in[191:160]) < 0 &&
      $signed(meas_scaled_in[191:160]) > -32767
      |=> live_i[5] == $past(meas_scaled_in[175:160]) && live_i[5] > 16'h8001;
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative value misencoded");

  property p_snap;
    @(posedge clock_in) disable iff (sys_rst_in)
      state_reg != ST_IDLE |=> $stable(snap_f[0]) && $stable(snap_i[0]);
  endproperty
  a_snap: assert property (p_snap)
    else $error("snapshot changed during a response");

  property p_addr;
    @(posedge clock_in)
      $past(sys_rst_in) && !sys_rst_in |-> slave_addr_out == 8'hf0;
  endproperty
  a_addr: assert property (p_addr)
    else $error("reset slave address not 240");

  property p_bad_fc;
    @(posedge clock_in) disable iff (sys_rst_in)
      frame_end && frame_ok && req_reg[1] == 8'h05
      |=> state_reg == ST_SEND && kind_reg == RK_EXC && exc_reg == 8'h01
      ##[1:3] tx_go_reg;
  endproperty
  a_bad_fc: assert property (p_bad_fc)
    else $error("unsupported function not refused");
endmodule

// file: bench/mbrm_master.sv
// modbus rtu master model on the rs-485 line
`timescale 1ns/1ps
module mbrm_master #(parameter int BIT_CYC = 16) (
  input wire logic clock_in,
  input wire logic line_in,
  output logic line_out = 1'b1,
  output logic [7:0] byte_out,
  output logic stb_out = 1'b0
);
  // ==========
  // bus model
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c = 16'hffff;
    foreach (q[i]) begin
      c ^= q[i];
      repeat (8) c = c[0] ? c >> 1 ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] q[$]);
    logic [15:0] c;
    logic [10:0] w;
    c = crc(q);
    q = {q, c[7:0], c[15:8]};
    foreach (q[i]) begin
      w = {2'b11, q[i], 1'b0};
      for (int k = 0; k < 11; k++) begin
        @(posedge clock_in) #1 line_out = w[k];
        repeat (BIT_CYC - 1) @(posedge clock_in);
      end
    end
  endtask
  // sample mid-bit so edge jitter of the slave does not matter
  always begin
    @(negedge line_in);
    repeat (BIT_CYC * 3 / 2) @(posedge clock_in);
    for (int i = 0; i < 8; i++) begin
      byte_out[i] = line_in;
      repeat (BIT_CYC) @(posedge clock_in);
    end
    #1 stb_out = 1'b1;
    @(posedge clock_in) #1 stb_out = 1'b0;
  end
endmodule

// file: bench/tb_mbrm_regmap.sv
// self-checking bench for the register map
`timescale 1ns/1ps
module tb_mbrm_regmap;
  // ==========
  // stimulus and checks
  logic clk = 1'b0, rst = 1'b1, upd = 1'b0, ase = 1'b0;
  logic tx, de, stb, line, bsy;
  logic [671:0] f32 = '0, sc = '0;
  logic [20:0] av = 21'h1fffbf;
  logic [7:0] sa, rb, exp_q[$], rs[$], rq[$];
  logic [15:0] lf = 16'had4a;
  int n_fail = 0, comparisons = 0;
  always #50 clk = ~clk;
  mbrm_regmap #(.GAP_CYC(200), .BIT_CYC(16)) dut (.clock_in(clk),
    .sys_rst_in(rst), .rs485_rx_in(line), .addr_set_in(ase),
    .addr_in(8'h11), .meas_update_in(upd), .meas_f32_in(f32),
    .meas_scaled_in(sc), .meas_avail_in(av), .rs485_tx_out(tx),
    .rs485_de_out(de), .busy_out(bsy), .slave_addr_out(sa));
  mbrm_master #(.BIT_CYC(16)) m (.clock_in(clk), .line_in(de ? tx : 1'b1),
    .line_out(line), .byte_out(rb), .stb_out(stb));
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic test_done();
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] w);
    comparisons++;
    if (g !== w) begin
      n_fail++;
      $display("Error %0t: %h %h", $time, g, w);
    end
  endtask
  always @(posedge stb) begin
    chk(rb, exp_q.size() ? exp_q.pop_front() : ~rb);
    chk({7'h00, bsy}, 8'h01);
  end
  task automatic pair(input int q);
    int b = q * 32;
    rs = {rs, f32[b+8+:8], f32[b+:8], f32[b+24+:8], f32[b+16+:8]};
  endtask
  task automatic pulse();
    upd = 1'b1;
    @(posedge clk) #1 upd = 1'b0;
  endtask
  task automatic xfer();
    logic [15:0] c;
    int k;
    c = m.crc(rs);
    exp_q = {rs, c[7:0], c[15:8]};
    m.send(rq);
    for (k = 0; k < 9999 && (exp_q.size() || de !== 1'b0); k++)
      @(posedge clk);
    if (k == 9999) begin
      chk(8'h00, 8'h01);
      test_done();
    end
    chk({6'h00, bsy, de}, 8'h00);
  endtask
  initial begin
    for (int i = 0; i < 42; i++) begin
      f32[i*16+:16] = lf;
      lf = nxt(lf);
    end
    sc[64+:192] = {-32'sd32766, 32'sd0, -32'sd5, -32'sd32767, 32'sd32767,
      32'sd32766};
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    pulse();
    chk(sa, 8'hf0);
    rq = {8'hf0, 8'h03, 8'h00, 8'h06, 8'h00, 8'h04};
    rs = {8'hf0, 8'h03, 8'h08};
    pair(2);
    pair(3);
    fork
      xfer();
      begin
        repeat (1700) @(posedge clk);
        #1 f32 = ~f32;
        pulse();
      end
    join
    rq = {8'hf0, 8'h03, 8'h01, 8'h03, 8'h00, 8'h06};
    rs = {8'hf0, 8'h03, 8'h0c, 8'h7f, 8'hfe, 8'h7f, 8'hff, 8'h80, 8'h01,
      8'hff, 8'hfb, 8'h80, 8'h00, 8'h80, 8'h02};
    xfer();
    rq = {8'hf0, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
    rs = {8'hf0, 8'h85, 8'h01};
    xfer();
    rq = {8'hf0, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
    rs = {8'hf0, 8'h90, 8'h02};
    xfer();
    rq = {8'hf0, 8'h2b, 8'h0e, 8'h01, 8'h00};
    rs = {8'hf0, 8'h2b, 8'h0e, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00,
      8'h01, 8'h5a};
    xfer();
    rq = {8'hf0, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02};
    rs = {8'hf0, 8'h83, 8'h02};
    xfer();
    #1 ase = 1'b1;
    @(posedge clk) #1 ase = 1'b0;
    chk(sa, 8'h11);
    rq = {8'h11, 8'h03, 8'h00, 8'h40, 8'h00, 8'h02};
    rs = {8'h11, 8'h03, 8'h04};
    pair(20);
    xfer();
    rq = {8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    rs = {8'h11, 8'h83, 8'h03};
    xfer();
    test_done();
  end
endmodule
